// File: dv/boundary_scan_tap_tb.sv
// Self-checking testbench of the boundary scan test access port
`timescale 1ns/1ps
module boundary_scan_tap_tb import boundary_scan_test_pkg::*;;
    // ------------------------------------------------------------
    // Signals, design and controller
    // ------------------------------------------------------------
    logic       i_clk, i_reset, tck, tms, tdi, trst_n, tdo, tdo_oe_n, test_mode;
    logic [7:0] pin_in, core_in, core_out, pin_out;
    logic [63:0] dout;
    logic [63:0] mask;
    int         mismatches, comparisons;
    localparam logic [63:0] PAT = 64'h0000_9e37_79b9_7f4a;
    typedef struct packed {
        logic [3:0]  op;
        logic [7:0]  len;
        logic [31:0] cap;
        logic [7:0]  pout;
        logic        mode;
    } row_type;
    row_type rows [6] = '{
        '{OP_BYPASS, 8'h01, {31'h0, BYPASS_CAPTURE}, 8'h3c, 1'b0},
        '{4'h7, 8'h01, {31'h0, BYPASS_CAPTURE}, 8'h3c, 1'b0},
        '{OP_IDCODE, 8'h20, ID_CODE, 8'h3c, 1'b0},
        '{OP_SAMPLE, 8'h10, 32'h3ca5, 8'h3c, 1'b0},
        '{OP_EXTEST, 8'h10, 32'h3ca5, 8'h9e, 1'b1},
        '{OP_CLAMP, 8'h01, {31'h0, BYPASS_CAPTURE}, 8'h9e, 1'b1}};

    // Five test pins between design and controller
    boundary_scan_tap dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
        .i_pin_in(pin_in), .o_core_in(core_in), .i_core_out(core_out),
        .o_pin_out(pin_out), .o_test_mode(test_mode));
    scan_controller_model ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
        .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Load an instruction and check the fixed capture pattern
    task automatic load(input logic [3:0] op);
        logic [63:0] o;
        ctl.scan_ir(64'(op), 4, o);
        check("ir_capture", 64'(o[3:0]), 64'(IR_CAPTURE));
    endtask
    // Let the system side see the crossed mode and latches
    task automatic settle(input logic mode, input logic [7:0] pout);
        repeat (10) @(posedge i_clk);
        #1;
        check("test_mode", 64'(test_mode), 64'(mode));
        check("pin_out", 64'(pin_out), 64'(pout));
        check("core_in", 64'(core_in), 64'(pin_in));
    endtask
    // Scan an identification read and check the code
    task automatic read_id();
        ctl.scan_dr(64'h0, 32, dout);
        check("idcode", dout, 64'(ID_CODE));
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #400us;
        mismatches++;
        finish_test();
    end
    initial begin
        i_reset = 1'b1;
        pin_in = 8'ha5;
        core_out = 8'h3c;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        ctl.reset_port(2);
        read_id();
        // Each instruction: path length, captured word, pins after update
        foreach (rows[i]) begin
            load(rows[i].op);
            ctl.scan_dr(PAT, 48, dout);
            mask = 64'hffff_ffff_ffff >> rows[i].len;
            check("path", (dout >> rows[i].len) & mask, PAT & mask);
            check("capture", dout & ((64'h1 << rows[i].len) - 64'h1), 64'(rows[i].cap));
            check("oe_shift", 64'(ctl.oe_shift), 64'h0);
            check("oe_idle", 64'(tdo_oe_n), 64'h1);
            settle(rows[i].mode, rows[i].pout);
        end
        // Preload under sample leaves pins functional, extest then drives it
        load(OP_SAMPLE);
        ctl.scan_dr(64'h5a00, 16, dout);
        settle(1'b0, 8'h3c);
        load(OP_EXTEST);
        settle(1'b1, 8'h5a);
        // Five mode-select ones return to reset and the identification opcode
        @(posedge i_clk);
        core_out <= 8'hc3;
        ctl.walk(8'h1f, 6);
        read_id();
        settle(1'b0, 8'hc3);
        // Test reset without clocks in mid-run drops bypass
        load(OP_BYPASS);
        ctl.reset_port(0);
        read_id();
        check("id_marker", 64'(dout[0]), 64'h1);
        check("id_fields", 64'(dout[31:1]), 64'({ID_VERSION, ID_PART, ID_MFR}));
        finish_test();
    end
endmodule

// File: dv/scan_controller_model.sv
// Board-level scan controller model that drives the test access port
`timescale 1ns/1ps
module scan_controller_model (
    output logic      o_tck,      // Test clock, still between frames
    output logic      o_tms,      // Mode select
    output logic      o_tdi,      // Data in, toggles when not shifting
    output logic      o_trst_n,   // Test reset, low active
    input  wire logic i_tdo,      // Data out
    input  wire logic i_tdo_oe_n  // Data out enable, low drives
);
    logic oe_seen;   // Enable at the last rising edge
    logic oe_shift;  // Enable at the last shift edge

    // Port held in reset until the bench takes it out
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b0;
    end

    // One clock cycle; data out taken just before the rising edge
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #3;
        tdo = i_tdo_oe_n ? ~i_tdo : i_tdo;  // Released line shows the inverse
        oe_seen = i_tdo_oe_n;
        o_tck = 1'b1;
        #3;
        o_tck = 1'b0;
    endtask

    // Walk the state graph, mode bits lsb first, data line toggling
    task automatic walk(input logic [7:0] tms, input int n);
        logic d;
        for (int i = 0; i < n; i++) tick(tms[i], ~o_tdi, d);
    endtask

    // Test reset low with n clocks given meanwhile, then go to idle
    task automatic reset_port(input int n);
        logic d;
        o_trst_n = 1'b0;
        #4;
        for (int i = 0; i < n; i++) tick(1'b1, ~o_tdi, d);
        o_trst_n = 1'b1;
        walk(8'h00, 1);
    endtask

    // Shift n bits lsb first, then through update to idle
    task automatic shift(input logic [63:0] din, input int n, output logic [63:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        oe_shift = oe_seen;
        walk(8'h01, 2);
    endtask

    // Instruction and data scans starting from idle
    task automatic scan_ir(input logic [63:0] din, input int n, output logic [63:0] dout);
        walk(8'h03, 4);
        shift(din, n, dout);
    endtask
    task automatic scan_dr(input logic [63:0] din, input int n, output logic [63:0] dout);
        walk(8'h01, 3);
        shift(din, n, dout);
    endtask
endmodule

// File: rtl/bit_sync.sv
// Two-stage level synchroniser, one per bit
`timescale 1ns/1ps
module bit_sync
    import boundary_scan_test_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,    // Destination clock
    input  wire logic             i_reset,  // Synchronous reset, active high
    input  wire logic [WIDTH-1:0] i_d,      // Level from another domain
    output logic      [WIDTH-1:0] o_q       // Synchronised level
);

    logic [WIDTH-1:0] stage [SYNC_STAGES];

    // ------------------------------------------------------------
    // Chain of flip-flops; only the last stage is visible
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stage[0] <= '0;
            stage[1] <= '0;
        end else begin
            stage[0] <= i_d;
            stage[1] <= stage[0];
        end
    end

    assign o_q = stage[SYNC_STAGES-1];

endmodule

// File: rtl/boundary_scan_tap.sv
// Boundary scan test access port with identification and boundary registers
`timescale 1ns/1ps

// How it works
// - Five test pins plus controller, instruction and data registers give board scan.
// - Bypass opcode puts one flip-flop between data in and data out.
// - Extest makes the boundary output cells drive the pins.
// - Sample captures pin inputs and core outputs without changing functional pins.
// - Sample also shifts and updates the output latches for a later extest.
// - Clamp selects bypass while the pins stay driven from the latches.
// - Entering test-logic-reset loads the identification opcode into the instruction register.
// - Low test reset forces test-logic-reset at once, no clock needed.
// - A 32-bit identification code holds version, part and manufacturer fields.
// - Identification opcode routes the serial path through the identification register.
// - Capture-DR with identification opcode loads the fixed code for shifting.
// - Bit 31 is nearest data in, bit 0 leaves first on data out.
module boundary_scan_tap
    import boundary_scan_test_pkg::*;
#(
    parameter int                  N_IN    = N_IN_DEFAULT,   // Scanned input pins
    parameter int                  N_OUT   = N_OUT_DEFAULT,  // Scanned output pins
    parameter logic [ID_WIDTH-1:0] ID_WORD = ID_CODE         // Identification word
) (
    input  wire logic             i_clk,       // System clock, 50 MHz
    input  wire logic             i_reset,     // System reset, synchronous
    input  wire logic             i_tck,       // Test clock from the board
    input  wire logic             i_tms,       // Test mode select
    input  wire logic             i_tdi,       // Test data in
    input  wire logic             i_trst_n,    // Test reset, asynchronous, low
    output logic                  o_tdo,       // Test data out
    output logic                  o_tdo_oe_n,  // Data out enable, low drives
    input  wire logic [N_IN-1:0]  i_pin_in,    // Input pins of the chip
    output logic      [N_IN-1:0]  o_core_in,   // Inputs handed to the core
    input  wire logic [N_OUT-1:0] i_core_out,  // Functional outputs of the core
    output logic      [N_OUT-1:0] o_pin_out,   // Output pins of the chip
    output logic                  o_test_mode  // Pins driven by scan cells
);

    localparam int BSR_LEN = N_IN + N_OUT;

    // ------------------------------------------------------------
    // Test clock domain state
    // ------------------------------------------------------------
    tap_state_type         state;
    tap_state_type         next_state;
    logic [IR_WIDTH-1:0]   ir;
    logic [IR_WIDTH-1:0]   ir_shift;
    logic                  bypass_bit;
    logic [ID_WIDTH-1:0]   id_shift;
    logic [BSR_LEN-1:0]    bsr_shift;
    logic [BSR_LEN-1:0]    bsr_latch;
    logic                  update_toggle;
    logic [BSR_LEN-1:0]    bsr_sense;
    logic                  tck_sync_reset;
    logic                  pin_mode;

    // ------------------------------------------------------------
    // System clock domain state
    // ------------------------------------------------------------
    logic [1:0]            sys_ctrl;
    logic                  toggle_seen;
    logic [N_OUT-1:0]      drive_word;
    logic [N_IN-1:0]       pin_sys;

    // State decodes
    wire in_reset    = (state == ST_RESET);
    wire cap_dr      = (state == ST_CAP_DR);
    wire shift_dr    = (state == ST_SHIFT_DR);
    wire upd_dr      = (state == ST_UPD_DR);
    wire cap_ir      = (state == ST_CAP_IR);
    wire shift_ir    = (state == ST_SHIFT_IR);
    wire upd_ir      = (state == ST_UPD_IR);

    // Instruction decodes; anything unknown falls to bypass
    wire sel_bsr     = (ir == OP_EXTEST) || (ir == OP_SAMPLE);
    wire sel_id      = (ir == OP_IDCODE);
    wire sel_bypass  = !sel_bsr && !sel_id;
    wire extest_mode = (ir == OP_EXTEST) || (ir == OP_CLAMP);
    wire next_pin_mode = (ir_shift == OP_EXTEST) || (ir_shift == OP_CLAMP);

    // Serial output selection
    wire dr_out      = sel_id  ? id_shift[0] :
                       sel_bsr ? bsr_shift[0] : bypass_bit;
    wire next_tdo    = shift_ir ? ir_shift[0] : dr_out;
    wire shifting    = shift_ir || shift_dr;

    wire toggle_sys  = sys_ctrl[1];
    wire mode_sys    = sys_ctrl[0];
    wire new_word    = (toggle_sys != toggle_seen);

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------

    // State register, forced to reset by the test reset pin
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Next state from mode select
    always_comb begin
        case (state)
            ST_RESET:    next_state = i_tms ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = i_tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = i_tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = i_tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = i_tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = i_tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = i_tms ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = i_tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = i_tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = i_tms ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------

    // Shift stage: fixed pattern on capture, data in on shift
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            ir_shift <= IR_CAPTURE;
        end else if (cap_ir) begin
            ir_shift <= IR_CAPTURE;
        end else if (shift_ir) begin
            ir_shift <= {i_tdi, ir_shift[IR_WIDTH-1:1]};
        end
    end

    // Active instruction: identification after reset, new one on update
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            ir <= IR_RESET;
        end else if (in_reset) begin
            ir <= IR_RESET;
        end else if (upd_ir) begin
            ir <= ir_shift;
        end
    end

    // Pin mode registered beside the opcode, so the crossing never sees
    // a glitch of the opcode decode
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            pin_mode <= 1'b0;
        end else if (in_reset) begin
            pin_mode <= 1'b0;
        end else if (upd_ir) begin
            pin_mode <= next_pin_mode;
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------

    // Single-bit bypass path
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            bypass_bit <= BYPASS_CAPTURE;
        end else if (cap_dr) begin
            bypass_bit <= BYPASS_CAPTURE;
        end else if (shift_dr) begin
            bypass_bit <= i_tdi;
        end
    end

    // Identification register: bit 31 takes data in, bit 0 leaves first
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            id_shift <= ID_WORD;
        end else if (cap_dr && sel_id) begin
            id_shift <= ID_WORD;
        end else if (shift_dr && sel_id) begin
            id_shift <= {i_tdi, id_shift[ID_WIDTH-1:1]};
        end
    end

    // Boundary shift stage: inputs low, core outputs high
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            bsr_shift <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr_shift <= bsr_sense;
        end else if (shift_dr && sel_bsr) begin
            bsr_shift <= {i_tdi, bsr_shift[BSR_LEN-1:1]};
        end
    end

    // Output latches and their change toggle
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            bsr_latch     <= '0;
            update_toggle <= 1'b0;
        end else if (upd_dr && sel_bsr) begin
            bsr_latch     <= bsr_shift;
            update_toggle <= !update_toggle;
        end
    end

    // ------------------------------------------------------------
    // Data out, changed on the falling edge
    // ------------------------------------------------------------
    always_ff @(negedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            o_tdo      <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else begin
            o_tdo      <= next_tdo;
            o_tdo_oe_n <= !shifting;
        end
    end

    // ------------------------------------------------------------
    // Crossings
    // ------------------------------------------------------------

    // Test reset held as a synchronous clear for the sensing chain
    assign tck_sync_reset = !i_trst_n;

    // Pins and core outputs sensed on the test clock
    bit_sync #(.WIDTH(BSR_LEN)) sense_sync (
        .i_clk   (i_tck),
        .i_reset (tck_sync_reset),
        .i_d     ({i_core_out, i_pin_in}),
        .o_q     (bsr_sense)
    );

    // Mode level and update toggle onto the system clock
    bit_sync #(.WIDTH(2)) ctrl_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     ({update_toggle, pin_mode}),
        .o_q     (sys_ctrl)
    );

    // Input pins onto the system clock for the core
    bit_sync #(.WIDTH(N_IN)) pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     (i_pin_in),
        .o_q     (pin_sys)
    );

    // ------------------------------------------------------------
    // System clock side
    // ------------------------------------------------------------

    // Take the latched output word once its toggle has crossed; the
    // latch is stable for many test clocks after each update
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            toggle_seen <= 1'b0;
            drive_word  <= '0;
        end else if (new_word) begin
            toggle_seen <= toggle_sys;
            drive_word  <= bsr_latch[BSR_LEN-1:N_IN];
        end
    end

    // Pin drive: scan latches in extest or clamp, core otherwise
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pin_out   <= '0;
            o_core_in   <= '0;
            o_test_mode <= 1'b0;
        end else begin
            o_pin_out   <= mode_sys ? drive_word : i_core_out;
            o_core_in   <= pin_sys;
            o_test_mode <= mode_sys;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    AST_TMS_RESET: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        i_tms [*5] |=> (state == ST_RESET))
        else $error("five high mode selects did not reach reset");

    AST_IR_IDCODE: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        in_reset |=> (ir == OP_IDCODE) && sel_id)
        else $error("reset state did not load identification opcode");

    AST_ID_CAPTURE: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        (cap_dr && sel_id) |=> (id_shift == ID_WORD))
        else $error("identification code not captured");

    AST_ID_SHIFT: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        (shift_dr && sel_id) |=> (id_shift[ID_WIDTH-1] == $past(i_tdi))
            && (id_shift[ID_WIDTH-2:0] == $past(id_shift[ID_WIDTH-1:1])))
        else $error("identification register shifted wrong way");

    AST_ID_TDO: assert property (
        @(negedge i_tck) disable iff (!i_trst_n)
        (shift_dr && sel_id) |=> (o_tdo == $past(id_shift[0])))
        else $error("data out not fed from identification bit 0");

    AST_BYPASS_ONE_BIT: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        (shift_dr && (ir == OP_BYPASS)) ##1 shift_dr
            |-> (bypass_bit == $past(i_tdi)))
        else $error("bypass path is not one flip-flop");

    AST_CLAMP_PATH: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        (ir == OP_CLAMP) |-> sel_bypass && pin_mode && !sel_bsr)
        else $error("clamp must pick bypass with pins held");

    AST_MODE_ALIGN: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        pin_mode == extest_mode)
        else $error("registered pin mode disagrees with opcode");

    AST_SAMPLE_CAPTURE: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        (cap_dr && (ir == OP_SAMPLE)) |=>
            (bsr_shift == $past(bsr_sense)) && !extest_mode)
        else $error("sample capture wrong or pins disturbed");

    AST_PRELOAD: assert property (
        @(posedge i_tck) disable iff (!i_trst_n)
        (upd_dr && (ir == OP_SAMPLE)) |=>
            (bsr_latch == $past(bsr_shift))
            && (update_toggle != $past(update_toggle)))
        else $error("preload did not reach output latches");

    AST_EXTEST_DRIVE: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (mode_sys && $stable(drive_word)) |=> (o_pin_out == $past(drive_word)))
        else $error("extest pins not driven from latches");

endmodule

// File: rtl/boundary_scan_test_pkg.sv
// Constants, opcodes and state type of the boundary scan test access port
package boundary_scan_test_pkg;

    // ------------------------------------------------------------
    // Pins and synchroniser depth
    // ------------------------------------------------------------
    localparam int TAP_PIN_COUNT = 5;   // Mode select, clock, reset, data in, data out
    localparam int SYNC_STAGES   = 2;   // Flip-flops in every bit_sync chain; the latched output word crosses through one register

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int IR_WIDTH = 4;
    localparam logic [IR_WIDTH-1:0] OP_EXTEST  = 4'h0;
    localparam logic [IR_WIDTH-1:0] OP_SAMPLE  = 4'h1;
    localparam logic [IR_WIDTH-1:0] OP_IDCODE  = 4'h2;
    localparam logic [IR_WIDTH-1:0] OP_CLAMP   = 4'h3;
    localparam logic [IR_WIDTH-1:0] OP_BYPASS  = 4'hf;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;   // Fixed 01 pattern in low bits
    localparam logic [IR_WIDTH-1:0] IR_RESET   = OP_IDCODE;

    // ------------------------------------------------------------
    // Identification register layout
    // ------------------------------------------------------------
    localparam int ID_WIDTH    = 32;
    localparam int ID_VER_LSB  = 28;   // Version, bits 31..28
    localparam int ID_PART_LSB = 12;   // Part number, bits 27..12
    localparam int ID_MFR_LSB  = 1;    // Manufacturer, bits 11..1
    localparam logic [3:0]  ID_VERSION = 4'h1;       // Arbitrary value
    localparam logic [15:0] ID_PART    = 16'h5a3c;   // Arbitrary value
    localparam logic [10:0] ID_MFR     = 11'h123;    // Arbitrary value
    localparam logic [ID_WIDTH-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

    // ------------------------------------------------------------
    // Defaults of the boundary register and the bypass capture value
    // ------------------------------------------------------------
    localparam int N_IN_DEFAULT  = 8;
    localparam int N_OUT_DEFAULT = 8;
    localparam logic BYPASS_CAPTURE = 1'b0;

    // ------------------------------------------------------------
    // Sixteen-state controller, one-hot
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } tap_state_type;

endpackage
